/* File: inc/sbl_pkg.sv */
// Constants and types shared by the video subsystem shared buffer logic
package sbl_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] SBL_ADDR_CTRL    = 8'h00;
  localparam logic [7:0] SBL_ADDR_SPACING = 8'h04;
  localparam logic [7:0] SBL_ADDR_ERRORS  = 8'h08;
  localparam logic [7:0] SBL_ADDR_ROUTE   = 8'h0C;
  localparam logic [7:0] SBL_ADDR_STATUS  = 8'h10;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int SBL_OVF_LSB   = 0;
  localparam int SBL_OVF_W     = 8;
  localparam int SBL_PRIO_LSB  = 16;
  localparam int SBL_PRIO_W    = 3;
  localparam int SBL_GAP_W     = 8;
  localparam int SBL_PRV_LSB   = 0;
  localparam int SBL_RSZ_LSB   = 8;
  localparam int SBL_HIST_LSB  = 16;
  localparam int SBL_FAULT_PIXEL_READ_ERROR_BIT = 0;
  localparam int SBL_DARK_BIT  = 1;
  localparam int SBL_ROUTE_W   = 7;
  localparam int SBL_PIX_W     = 10;
  localparam int SBL_YUV_W     = 16;
  localparam int SBL_NREQ      = 3;
  localparam int SBL_FIFO_D    = 16;

  // Route bit positions
  localparam int SBL_VIDEO_PORT_ENABLE_BIT  = 0;
  localparam int SBL_WEN_BIT   = 1;
  localparam int SBL_M2R_BIT   = 2;
  localparam int SBL_PSRC_BIT  = 3;
  localparam int SBL_RPORT_BIT = 4;
  localparam int SBL_MPORT_BIT = 5;
  localparam int SBL_RSEL_BIT  = 6;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [SBL_PRIO_W-1:0]  SBL_PRIO_RST  = 3'h0;
  localparam logic [SBL_GAP_W-1:0]   SBL_GAP_RST   = 8'h00;
  localparam logic [SBL_OVF_W-1:0]   SBL_OVF_RST   = 8'h00;
  localparam logic [1:0]             SBL_ERR_RST   = 2'h0;
  localparam logic [SBL_ROUTE_W-1:0] SBL_ROUTE_RST = 7'h00;

  // Requester index
  localparam int SBL_REQ_PRV  = 0;
  localparam int SBL_REQ_RSZ  = 1;
  localparam int SBL_REQ_HIST = 2;

  typedef enum logic [1:0] {SBL_IDLE, SBL_WAIT_ACK} sbl_arb_state_t;

endpackage : sbl_pkg

/* File: core/sbl_arbiter.sv */
// Shared buffer logic: DMA read arbiter, error flags, capture pixel FIFO, routing
//
// Functional notes
// - Reset returns all registers to defaults
// - Priority field drives memory interface priority
// - Three per-module read request spacing fields
// - Always active, no enable control (the video port here is gated by route bit 0)
// - Eight sticky write buffer overflow flags
// - Fault pixel read failure sets flag
// - Dark/shading read failure sets flag
// - Registers writable anytime, take effect immediately
// - Raw 10-bit pixels fan out simultaneously
// - Preview YUV 4:2:2 output routed onward
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Synchronous FIFO
// ------------------------------------------------------------------
module sbl_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wptr_reg;
  logic [AW-1:0]    rptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o  = mem_reg[rptr_reg];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wptr_reg  <= '0;
      rptr_reg  <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= rptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : sbl_fifo

// ------------------------------------------------------------------
// Top
// ------------------------------------------------------------------
module sbl_arbiter (
  input  wire logic                          clk_i,
  input  wire logic                          srst_i,
  // Register port
  input  wire logic [7:0]                    addr_i,
  input  wire logic [31:0]                   wdata_i,
  input  wire logic                          wr_i,
  input  wire logic                          rd_i,
  output logic      [31:0]                   rdata_o,
  // DMA read requests from preview, resizer, histogram
  input  wire logic [sbl_pkg::SBL_NREQ-1:0]  rd_req_i,
  output logic      [sbl_pkg::SBL_NREQ-1:0]  rd_grant_o,
  output logic                               dma_req_o,
  output logic      [1:0]                    dma_src_o,
  input  wire logic                          dma_ack_i,
  output logic      [sbl_pkg::SBL_PRIO_W-1:0] mem_priority_o,
  // Error events
  input  wire logic [sbl_pkg::SBL_OVF_W-1:0] wbuf_ovf_i,
  input  wire logic                          fpc_active_i,
  input  wire logic                          fpc_read_fail_i,
  input  wire logic                          dark_active_i,
  input  wire logic                          dark_read_fail_i,
  // Capture raw pixel stream
  input  wire logic [sbl_pkg::SBL_PIX_W-1:0] cap_pix_i,
  input  wire logic                          cap_valid_i,
  output logic                               cap_ready_o,
  output logic      [sbl_pkg::SBL_PIX_W-1:0] vp_pix_o,
  output logic                               vp_valid_o,
  input  wire logic                          prv_ready_i,
  input  wire logic                          stats_ready_i,
  input  wire logic                          hist_ready_i,
  // Preview YUV stream to resizer
  input  wire logic [sbl_pkg::SBL_YUV_W-1:0] prv_yuv_i,
  input  wire logic                          prv_yuv_valid_i,
  output logic      [sbl_pkg::SBL_YUV_W-1:0] rsz_yuv_o,
  output logic                               rsz_yuv_valid_o
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [sbl_pkg::SBL_PRIO_W-1:0]  prio_reg;
  logic [sbl_pkg::SBL_GAP_W-1:0]   gap_cfg_reg [sbl_pkg::SBL_NREQ];
  logic [sbl_pkg::SBL_OVF_W-1:0]   ovf_reg;
  logic                            fault_pixel_read_error_reg;
  logic                            dark_reg;
  logic [sbl_pkg::SBL_ROUTE_W-1:0] route_reg;
  logic [31:0]                     rdata_next;

  logic [sbl_pkg::SBL_GAP_W-1:0]   gap_cnt_reg [sbl_pkg::SBL_NREQ];
  sbl_pkg::sbl_arb_state_t         state_reg;
  logic [1:0]                      sel_reg;
  logic [sbl_pkg::SBL_NREQ-1:0]    eligible;
  logic                            cap_ovf_ev;

  logic                            fifo_in_ready;
  logic [sbl_pkg::SBL_PIX_W-1:0]   fifo_pix;
  logic                            fifo_valid;
  logic                            fan_ready;
  logic                            vp_load;

  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] off);
    wr_hit = (a == off);
  endfunction : wr_hit

  function automatic logic [sbl_pkg::SBL_GAP_W-1:0] gap_field(
    input logic [31:0] d, input int lsb);
    gap_field = d[lsb +: sbl_pkg::SBL_GAP_W];
  endfunction : gap_field

  wire wr_ctrl  = wr_i && wr_hit(addr_i, sbl_pkg::SBL_ADDR_CTRL);
  wire wr_space = wr_i && wr_hit(addr_i, sbl_pkg::SBL_ADDR_SPACING);
  wire wr_err   = wr_i && wr_hit(addr_i, sbl_pkg::SBL_ADDR_ERRORS);
  wire wr_route = wr_i && wr_hit(addr_i, sbl_pkg::SBL_ADDR_ROUTE);

  // ----------------------------------------------------------------
  // Configuration, no module enable bit: logic always runs, except the video port gated by route bit 0
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      prio_reg <= sbl_pkg::SBL_PRIO_RST;
    end else if (wr_ctrl) begin
      prio_reg <= wdata_i[sbl_pkg::SBL_PRIO_LSB +: sbl_pkg::SBL_PRIO_W];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      gap_cfg_reg[sbl_pkg::SBL_REQ_PRV]  <= sbl_pkg::SBL_GAP_RST;
      gap_cfg_reg[sbl_pkg::SBL_REQ_RSZ]  <= sbl_pkg::SBL_GAP_RST;
      gap_cfg_reg[sbl_pkg::SBL_REQ_HIST] <= sbl_pkg::SBL_GAP_RST;
    end else if (wr_space) begin
      gap_cfg_reg[sbl_pkg::SBL_REQ_PRV]  <= gap_field(wdata_i, sbl_pkg::SBL_PRV_LSB);
      gap_cfg_reg[sbl_pkg::SBL_REQ_RSZ]  <= gap_field(wdata_i, sbl_pkg::SBL_RSZ_LSB);
      gap_cfg_reg[sbl_pkg::SBL_REQ_HIST] <= gap_field(wdata_i, sbl_pkg::SBL_HIST_LSB);
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      route_reg <= sbl_pkg::SBL_ROUTE_RST;
    end else if (wr_route) begin
      route_reg <= wdata_i[sbl_pkg::SBL_ROUTE_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Sticky error flags, write one to clear, set wins
  // ----------------------------------------------------------------
  assign cap_ovf_ev = cap_valid_i && !fifo_in_ready;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ovf_reg <= sbl_pkg::SBL_OVF_RST;
    end else begin
      ovf_reg <= (ovf_reg & ~({sbl_pkg::SBL_OVF_W{wr_ctrl}}
                 & wdata_i[sbl_pkg::SBL_OVF_LSB +: sbl_pkg::SBL_OVF_W]))
                 | wbuf_ovf_i
                 | {{(sbl_pkg::SBL_OVF_W-1){1'b0}}, cap_ovf_ev};
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      fault_pixel_read_error_reg <= sbl_pkg::SBL_ERR_RST[0];
      dark_reg  <= sbl_pkg::SBL_ERR_RST[1];
    end else begin
      fault_pixel_read_error_reg <= (fault_pixel_read_error_reg && !(wr_err && wdata_i[sbl_pkg::SBL_FAULT_PIXEL_READ_ERROR_BIT]))
                   || (fpc_active_i && fpc_read_fail_i);
      dark_reg  <= (dark_reg && !(wr_err && wdata_i[sbl_pkg::SBL_DARK_BIT]))
                   || (dark_active_i && dark_read_fail_i);
    end
  end

  // ----------------------------------------------------------------
  // Read port, data one cycle after the strobe
  // ----------------------------------------------------------------
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (rd_i) begin
      case (addr_i)
        sbl_pkg::SBL_ADDR_CTRL: begin
          rdata_next[sbl_pkg::SBL_OVF_LSB +: sbl_pkg::SBL_OVF_W]   = ovf_reg;
          rdata_next[sbl_pkg::SBL_PRIO_LSB +: sbl_pkg::SBL_PRIO_W] = prio_reg;
        end
        sbl_pkg::SBL_ADDR_SPACING: begin
          rdata_next[sbl_pkg::SBL_PRV_LSB +: sbl_pkg::SBL_GAP_W] =
            gap_cfg_reg[sbl_pkg::SBL_REQ_PRV];
          rdata_next[sbl_pkg::SBL_RSZ_LSB +: sbl_pkg::SBL_GAP_W] =
            gap_cfg_reg[sbl_pkg::SBL_REQ_RSZ];
          rdata_next[sbl_pkg::SBL_HIST_LSB +: sbl_pkg::SBL_GAP_W] =
            gap_cfg_reg[sbl_pkg::SBL_REQ_HIST];
        end
        sbl_pkg::SBL_ADDR_ERRORS: begin
          rdata_next[sbl_pkg::SBL_FAULT_PIXEL_READ_ERROR_BIT] = fault_pixel_read_error_reg;
          rdata_next[sbl_pkg::SBL_DARK_BIT]  = dark_reg;
        end
        sbl_pkg::SBL_ADDR_ROUTE: begin
          rdata_next[sbl_pkg::SBL_ROUTE_W-1:0] = route_reg;
        end
        sbl_pkg::SBL_ADDR_STATUS: begin
          rdata_next[2:0] = eligible;
          rdata_next[3]   = (state_reg == sbl_pkg::SBL_WAIT_ACK);
          rdata_next[4]   = fifo_valid;
        end
        default: begin
          rdata_next = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_o <= 32'h0000_0000;
    end else begin
      rdata_o <= rdata_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mem_priority_o <= sbl_pkg::SBL_PRIO_RST;
    end else begin
      mem_priority_o <= prio_reg;
    end
  end

  // ----------------------------------------------------------------
  // Read request arbiter with per-module spacing
  // ----------------------------------------------------------------
  // Fixed order preview > resizer > histogram; spacing keeps any one
  // module from starving the others when its gap is programmed.
  always_comb begin
    for (int i = 0; i < sbl_pkg::SBL_NREQ; i++) begin
      eligible[i] = rd_req_i[i] && (gap_cnt_reg[i] == '0);
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_reg  <= sbl_pkg::SBL_IDLE;
      sel_reg    <= 2'h0;
      dma_req_o  <= 1'b0;
      dma_src_o  <= 2'h0;
      rd_grant_o <= '0;
    end else begin
      rd_grant_o <= '0;
      case (state_reg)
        sbl_pkg::SBL_IDLE: begin
          if (eligible != '0) begin
            sel_reg   <= eligible[0] ? 2'h0 : (eligible[1] ? 2'h1 : 2'h2);
            dma_src_o <= eligible[0] ? 2'h0 : (eligible[1] ? 2'h1 : 2'h2);
            dma_req_o <= 1'b1;
            state_reg <= sbl_pkg::SBL_WAIT_ACK;
          end
        end
        sbl_pkg::SBL_WAIT_ACK: begin
          if (dma_ack_i) begin
            dma_req_o           <= 1'b0;
            rd_grant_o[sel_reg] <= 1'b1;
            state_reg           <= sbl_pkg::SBL_IDLE;
          end
        end
        default: begin
          state_reg <= sbl_pkg::SBL_IDLE;
          dma_req_o <= 1'b0;
        end
      endcase
    end
  end

  // Gap counters load on acceptance, then count down once per clock cycle
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < sbl_pkg::SBL_NREQ; i++) begin
        gap_cnt_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < sbl_pkg::SBL_NREQ; i++) begin
        if (state_reg == sbl_pkg::SBL_WAIT_ACK && dma_ack_i && sel_reg == 2'(i)) begin
          gap_cnt_reg[i] <= gap_cfg_reg[i];
        end else if (gap_cnt_reg[i] != '0) begin
          gap_cnt_reg[i] <= gap_cnt_reg[i] - 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Capture video port: FIFO then simultaneous fan-out
  // ----------------------------------------------------------------
  sbl_fifo #(
    .WIDTH (sbl_pkg::SBL_PIX_W),
    .DEPTH (sbl_pkg::SBL_FIFO_D)
  ) u_fifo (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .in_data_i   (cap_pix_i),
    .in_valid_i  (cap_valid_i),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_pix),
    .out_valid_o (fifo_valid),
    .out_ready_i (vp_load)
  );

  // A beat leaves only when all three consumers take it together
  assign fan_ready = prv_ready_i && stats_ready_i && hist_ready_i;
  assign vp_load   = route_reg[sbl_pkg::SBL_VIDEO_PORT_ENABLE_BIT] && (!vp_valid_o || fan_ready);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cap_ready_o <= 1'b0;
    end else begin
      cap_ready_o <= fifo_in_ready;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      vp_pix_o   <= '0;
      vp_valid_o <= 1'b0;
    end else if (vp_load) begin
      vp_pix_o   <= fifo_pix;
      vp_valid_o <= fifo_valid;
    end else if (fan_ready || !route_reg[sbl_pkg::SBL_VIDEO_PORT_ENABLE_BIT]) begin
      vp_valid_o <= 1'b0;
    end
  end

  // Preview YUV to resizer only on the direct on-the-fly path
  wire rsz_path = route_reg[sbl_pkg::SBL_RPORT_BIT] && !route_reg[sbl_pkg::SBL_RSEL_BIT];

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rsz_yuv_o       <= '0;
      rsz_yuv_valid_o <= 1'b0;
    end else begin
      rsz_yuv_o       <= prv_yuv_i;
      rsz_yuv_valid_o <= prv_yuv_valid_i && rsz_path;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_prio_follow: assert property (@(posedge clk_i) disable iff (srst_i)
    wr_ctrl |=> ##1 mem_priority_o ==
      $past(wdata_i[sbl_pkg::SBL_PRIO_LSB +: sbl_pkg::SBL_PRIO_W], 2))
    else $error("priority output did not follow write");

  a_gap_spacing: assert property (@(posedge clk_i) disable iff (srst_i)
    (state_reg == sbl_pkg::SBL_IDLE && gap_cnt_reg[sbl_pkg::SBL_REQ_PRV] != '0)
    |=> !(state_reg == sbl_pkg::SBL_WAIT_ACK && sel_reg == 2'h0))
    else $error("preview granted inside its gap");

  a_ovf_sticky: assert property (@(posedge clk_i) disable iff (srst_i)
    (ovf_reg[1] && !wr_ctrl) |=> ovf_reg[1])
    else $error("overflow flag dropped without clear");

  a_ovf_set: assert property (@(posedge clk_i) disable iff (srst_i)
    wbuf_ovf_i[7] |=> ovf_reg[7])
    else $error("overflow event not recorded");

  a_fault_pixel_read_error_set: assert property (@(posedge clk_i) disable iff (srst_i)
    (fpc_active_i && fpc_read_fail_i) |=> fault_pixel_read_error_reg)
    else $error("fault pixel read error not set");

  a_dark_gate: assert property (@(posedge clk_i) disable iff (srst_i)
    (!dark_reg && !dark_active_i) |=> !dark_reg)
    else $error("dark flag set while inactive");

  a_rdata_late: assert property (@(posedge clk_i) disable iff (srst_i)
    (rd_i && addr_i == sbl_pkg::SBL_ADDR_ERRORS) |=> rdata_o[0] == $past(fault_pixel_read_error_reg))
    else $error("read data wrong in cycle after strobe");

  a_reset_vals: assert property (@(posedge clk_i)
    srst_i |=> (ovf_reg == '0 && prio_reg == '0 && !dark_reg && !fault_pixel_read_error_reg))
    else $error("register not at reset value");

  a_grant_ack: assert property (@(posedge clk_i) disable iff (srst_i)
    (state_reg == sbl_pkg::SBL_WAIT_ACK && dma_ack_i) |=> (rd_grant_o != '0 && !dma_req_o))
    else $error("acknowledged request not granted");

  a_rsz_route: assert property (@(posedge clk_i) disable iff (srst_i)
    rsz_yuv_valid_o |-> $past(route_reg[sbl_pkg::SBL_RPORT_BIT]))
    else $error("resizer fed while port disabled");

endmodule : sbl_arbiter

/* File: dv/sbl_mem_model.sv */
// Behavioural memory controller answering the shared buffer DMA read requests
`timescale 1ns/1ps
module sbl_mem_model (
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       dma_req_i,
  input  wire logic [1:0] dma_src_i,
  input  wire logic [3:0] delay_i,
  output logic            dma_ack_o,
  output logic      [1:0] last_src_o
);
  logic [3:0] wait_reg;

  // Ack is a one-cycle pulse; a nonzero delay mimics a busy memory port
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      dma_ack_o  <= 1'h0;
      wait_reg   <= 4'h0;
      last_src_o <= 2'h0;
    end else if (dma_ack_o) begin
      dma_ack_o <= 1'h0;
      wait_reg  <= 4'h0;
    end else if (dma_req_i) begin
      if (wait_reg >= delay_i) begin
        dma_ack_o  <= 1'h1;
        last_src_o <= dma_src_i;
      end else begin
        wait_reg <= wait_reg + 4'h1;
      end
    end
  end
endmodule : sbl_mem_model

/* File: dv/tb.sv */
// Self-checking testbench for the shared buffer logic
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_total++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, (a), (e)); end end
module tb;
  logic        clk_i = 1'h0;
  logic        srst_i = 1'h1;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, rdata_o, d;
  logic        wr_i = 1'h0, rd_i = 1'h0;
  logic [2:0]  rd_req_i = 3'h0, rd_grant_o, mem_priority_o;
  logic        dma_req_o, dma_ack_i;
  logic [1:0]  dma_src_o, last_src;
  logic [7:0]  wbuf_ovf_i = 8'h00;
  logic        fpc_active_i = 1'h0, fpc_read_fail_i = 1'h0;
  logic        dark_active_i = 1'h0, dark_read_fail_i = 1'h0;
  logic [9:0]  cap_pix_i = 10'h0, vp_pix_o, e;
  logic        cap_valid_i = 1'h0, cap_ready_o, vp_valid_o;
  logic        prv_ready_i = 1'h1, stats_ready_i = 1'h1, hist_ready_i = 1'h1;
  logic [15:0] prv_yuv_i = 16'h0, rsz_yuv_o;
  logic        prv_yuv_valid_i = 1'h0, rsz_yuv_valid_o;
  logic [3:0]  ack_dly = 4'h0;
  logic [9:0]  q[$];
  int          err_total = 0, num_checks = 0, cyc = 0, iv0, iv1;

  initial forever #10 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;

  sbl_arbiter DUT (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rd_req_i(rd_req_i), .rd_grant_o(rd_grant_o),
    .dma_req_o(dma_req_o), .dma_src_o(dma_src_o), .dma_ack_i(dma_ack_i),
    .mem_priority_o(mem_priority_o), .wbuf_ovf_i(wbuf_ovf_i), .fpc_active_i(fpc_active_i),
    .fpc_read_fail_i(fpc_read_fail_i), .dark_active_i(dark_active_i),
    .dark_read_fail_i(dark_read_fail_i), .cap_pix_i(cap_pix_i), .cap_valid_i(cap_valid_i),
    .cap_ready_o(cap_ready_o), .vp_pix_o(vp_pix_o), .vp_valid_o(vp_valid_o),
    .prv_ready_i(prv_ready_i), .stats_ready_i(stats_ready_i), .hist_ready_i(hist_ready_i),
    .prv_yuv_i(prv_yuv_i), .prv_yuv_valid_i(prv_yuv_valid_i), .rsz_yuv_o(rsz_yuv_o),
    .rsz_yuv_valid_o(rsz_yuv_valid_o));

  sbl_mem_model mem (.clk_i(clk_i), .srst_i(srst_i), .dma_req_i(dma_req_o),
    .dma_src_i(dma_src_o), .delay_i(ack_dly), .dma_ack_o(dma_ack_i), .last_src_o(last_src));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'h1;
    @(posedge clk_i);
    wr_i    <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'h1;
    @(posedge clk_i);
    rd_i   <= 1'h0;
    #1 d = rdata_o;
  endtask : rd

  task automatic wgrant(input logic [2:0] m);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      #1 n++;
    end while ((rd_grant_o & m) === 3'h0 && n < 300);
    if (n >= 300) begin
      err_total++;
      $display("wrong value at %0t: no grant", $time);
      end_of_test;
    end
  endtask : wgrant

  // Interval between two grants of one requester held busy
  task automatic span(input int k, input logic [7:0] g, output int iv);
    int t0;
    wr(sbl_pkg::SBL_ADDR_SPACING, {8'h00, g, g, g});
    @(posedge clk_i);
    rd_req_i[k] <= 1'h1;
    wgrant(3'h1 << k);
    `CHK(last_src, k[1:0])
    t0 = cyc;
    wgrant(3'h1 << k);
    iv = cyc - t0;
    @(posedge clk_i);
    rd_req_i[k] <= 1'h0;
    repeat (20) @(posedge clk_i);
  endtask : span

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    int n;
    repeat (12) @(posedge clk_i);
    srst_i <= 1'h0;
    wr(8'h14, 32'hFFFFFFFF);
    for (n = 0; n < 6; n++) begin
      rd(8'(n * 4));
      `CHK(d, 32'h0)
    end
    `CHK(mem_priority_o, 3'h0)
    $display("test reset values done");

    wr(sbl_pkg::SBL_ADDR_CTRL, 32'h0005_0000);
    @(posedge clk_i);
    #1 `CHK(mem_priority_o, 3'h5)
    rd(sbl_pkg::SBL_ADDR_CTRL);
    `CHK(d, 32'h0005_0000)
    for (n = 0; n < 8; n++) begin
      @(posedge clk_i);
      wbuf_ovf_i <= 8'h01 << n;
      @(posedge clk_i);
      wbuf_ovf_i <= 8'h00;
      rd(sbl_pkg::SBL_ADDR_CTRL);
      `CHK(d[7:0], 8'hFF >> (7 - n))
    end
    wr(sbl_pkg::SBL_ADDR_CTRL, 32'h0000_0008);
    rd(sbl_pkg::SBL_ADDR_CTRL);
    `CHK(d, 32'h0000_00F7)
    wr(sbl_pkg::SBL_ADDR_CTRL, 32'h0000_00FF);
    rd(sbl_pkg::SBL_ADDR_CTRL);
    `CHK(d, 32'h0)
    $display("test priority and overflow done");

    @(posedge clk_i);
    {fpc_read_fail_i, dark_read_fail_i} <= 2'h3;
    rd(sbl_pkg::SBL_ADDR_ERRORS);
    `CHK(d, 32'h0)
    @(posedge clk_i);
    {fpc_active_i, dark_active_i} <= 2'h3;
    @(posedge clk_i);
    {fpc_read_fail_i, dark_read_fail_i} <= 2'h0;
    rd(sbl_pkg::SBL_ADDR_ERRORS);
    `CHK(d, 32'h3)
    wr(sbl_pkg::SBL_ADDR_ERRORS, 32'h1);
    rd(sbl_pkg::SBL_ADDR_ERRORS);
    `CHK(d, 32'h2)
    wr(sbl_pkg::SBL_ADDR_ERRORS, 32'h2);
    rd(sbl_pkg::SBL_ADDR_ERRORS);
    `CHK(d, 32'h0)
    $display("test read failure flags done");

    for (n = 0; n < 3; n++) begin
      @(posedge clk_i);
      rd_req_i <= 3'h7 << n;
      wgrant(3'h7);
      `CHK(rd_grant_o, 3'h1 << n)
      @(posedge clk_i);
      rd_req_i <= 3'h0;
      repeat (10) @(posedge clk_i);
    end
    for (n = 0; n < 3; n++) begin
      ack_dly <= 4'(n * 3);
      span(n, 8'h00, iv0);
      span(n, 8'(n * 2 + 3), iv1);
      `CHK(iv1 - iv0, n * 2 + 3)
    end
    $display("test request spacing done");

    wr(sbl_pkg::SBL_ADDR_ROUTE, 32'h0000_0001);
    @(posedge clk_i);
    prv_ready_i <= 1'h0;
    #1;
    // Slow cadence so the late ready flag is settled before each beat
    for (n = 0; n < 40 && cap_ready_o === 1'h1; n++) begin
      @(posedge clk_i);
      cap_pix_i   <= 10'(n + 10'h155);
      cap_valid_i <= 1'h1;
      q.push_back(10'(n + 10'h155));
      @(posedge clk_i);
      cap_valid_i <= 1'h0;
      repeat (2) @(posedge clk_i);
      #1;
    end
    `CHK(q.size() >= 16, 1'h1)
    @(posedge clk_i);
    cap_valid_i <= 1'h1;
    @(posedge clk_i);
    cap_valid_i <= 1'h0;
    rd(sbl_pkg::SBL_ADDR_CTRL);
    `CHK(d[0], 1'h1)
    // Look after the edge: a beat seen here with all readies high leaves at the next edge
    for (n = 0; n < 400 && q.size() > 0; n++) begin
      @(posedge clk_i);
      prv_ready_i   <= 1'h1;
      stats_ready_i <= (n % 3 != 0);
      hist_ready_i  <= (n % 4 != 1);
      #1;
      if (vp_valid_o && prv_ready_i && stats_ready_i && hist_ready_i) begin
        e = q.pop_front();
        `CHK(vp_pix_o, e)
      end
    end
    `CHK(q.size(), 0)
    rd(sbl_pkg::SBL_ADDR_STATUS);
    `CHK(d[4], 1'h0)
    $display("test capture stream done");

    for (n = 0; n < 2; n++) begin
      wr(sbl_pkg::SBL_ADDR_ROUTE, (n == 0) ? 32'h0000_0011 : 32'h0000_0051);
      @(posedge clk_i);
      prv_yuv_i       <= 16'hA5C3;
      prv_yuv_valid_i <= 1'h1;
      @(posedge clk_i);
      prv_yuv_valid_i <= 1'h0;
      #1 `CHK(rsz_yuv_valid_o, n == 0)
      if (n == 0) `CHK(rsz_yuv_o, 16'hA5C3)
    end
    $display("test resizer path done");

    wr(sbl_pkg::SBL_ADDR_CTRL, 32'h0006_0000);
    @(posedge clk_i);
    srst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'h0;
    for (n = 0; n < 4; n++) begin
      rd(8'(n * 4));
      `CHK(d, 32'h0)
    end
    `CHK(mem_priority_o, 3'h0)
    $display("test mid-run reset done");
    end_of_test;
  end
endmodule : tb
